// file: hw/ivp_core.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// RL1: Table address is page base plus offset
// RL2: Fixed offsets 0x00 through 0x10 per source
// RL3: Software may rewrite table entries at run
// RL4: Table sources fetch handler address, then continue
// RL5: Power-fail request edge detected, never masked
// RL6: Power-fail blocks others except trap; jump 0x66
// RL7: Jump sources branch straight to vector slot
// RL8: Fixed priority trap down to serial port 1; here the clocked serial port ranks last, below serial port 1
// RL9: Only winner serviced; others stay pending
// RL10: Entries are two bytes, low then high
module ivp_core
    import ivp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Request sources
    input wire logic illegal_opcode_trap,
    input wire logic power_fail_input_n,
    input wire logic level0_req,
    input wire logic level1_req,
    input wire logic level2_req,
    input wire logic timer0_req,
    input wire logic timer1_req,
    input wire logic transfer_ch0_req,
    input wire logic transfer_ch1_req,
    input wire logic clocked_serial_req,
    input wire logic async_serial0_req,
    input wire logic async_serial1_req,
    // Core control
    input wire logic [7:0] vector_page_base,
    input wire logic int_enable,
    input wire logic [IVP_NSRC-1:0] src_enable,
    input wire logic power_fail_return,
    input wire logic core_ack,
    // Table read port
    output logic tbl_rd,
    output logic [15:0] tbl_addr,
    input wire logic [7:0] tbl_data,
    // Delivery to core
    output logic deliver,
    output logic [1:0] deliver_kind,
    output logic [15:0] deliver_target,
    output logic [3:0] deliver_src,
    output logic power_fail_active
);
    ivp_state_t state, next_state;
    logic pf_fall, pf_pend, next_pf_pend, pf_act, next_pf_act;
    logic [11:0] req;
    logic [11:0] grant;
    logic [3:0] win, next_win;
    logic [15:0] addr_q, next_addr;
    logic [7:0] lo_q, next_lo;
    logic next_rd, next_deliver;
    logic [1:0] next_kind;
    logic [15:0] next_target;
    logic [7:0] offs;

    // ------------------------------------------------------------
    // Power-fail edge detector
    // ------------------------------------------------------------
    ivp_edge_sync u_pf (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_n(power_fail_input_n),
        .fall(pf_fall)
    );

    // ------------------------------------------------------------
    // Request vector; slot 11 is the clocked serial port, lowest
    // ------------------------------------------------------------
    always_comb begin
        req = 12'h000;
        req[IVP_SRC_TRAP] = illegal_opcode_trap;
        req[IVP_SRC_NMI] = pf_pend; // No mask applies here [RL5]
        // Others held off while power-fail handler runs [RL6]
        if (int_enable && !pf_act) begin
            req[IVP_SRC_LVL0] = level0_req & src_enable[IVP_SRC_LVL0];
            req[IVP_SRC_LVL1] = level1_req & src_enable[IVP_SRC_LVL1];
            req[IVP_SRC_LVL2] = level2_req & src_enable[IVP_SRC_LVL2];
            req[IVP_SRC_TMR0] = timer0_req & src_enable[IVP_SRC_TMR0];
            req[IVP_SRC_TMR1] = timer1_req & src_enable[IVP_SRC_TMR1];
            req[IVP_SRC_XFR0] = transfer_ch0_req & src_enable[IVP_SRC_XFR0];
            req[IVP_SRC_XFR1] = transfer_ch1_req & src_enable[IVP_SRC_XFR1];
            req[IVP_SRC_SER0] = async_serial0_req & src_enable[IVP_SRC_SER0];
            req[IVP_SRC_SER1] = async_serial1_req & src_enable[IVP_SRC_SER1];
            req[11] = clocked_serial_req;
        end
    end

    // ------------------------------------------------------------
    // Fixed priority pick, lowest index wins
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_pri
            if (gi == 0) begin : g_top
                assign grant[gi] = req[gi]; // [RL8]
            end else begin : g_rest
                assign grant[gi] = req[gi] & ~|req[gi-1:0]; // [RL8] [RL9]
            end
        end
    endgenerate

    // Offset of a table source; two bytes per entry
    always_comb begin
        case (win)
            4'h3: offs = EXPANSION_ATTENTION_VECTOR; // [RL2]
            4'h4: offs = LEVEL2_VECTOR;
            4'h5: offs = TIMER0_VECTOR;
            4'h6: offs = TIMER1_VECTOR;
            4'h7: offs = TRANSFER_CH0_VECTOR;
            4'h8: offs = TRANSFER_CH1_VECTOR;
            4'h9: offs = ASYNC_SERIAL0_VECTOR;
            4'hA: offs = ASYNC_SERIAL1_VECTOR;
            4'hB: offs = CLOCKED_SERIAL_VECTOR;
            default: offs = EXPANSION_ATTENTION_VECTOR;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer: next values
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pf_pend = pf_pend | pf_fall; // Edge is latched until taken [RL5]
        next_pf_act = pf_act & ~power_fail_return;
        next_win = win;
        next_addr = addr_q;
        next_lo = lo_q;
        next_rd = 1'b0;
        next_deliver = deliver;
        next_kind = deliver_kind;
        next_target = deliver_target;
        case (state)
            IVP_IDLE: begin
                next_deliver = 1'b0;
                next_kind = IVP_KIND_NONE;
                if (grant[IVP_SRC_TRAP]) begin
                    next_win = 4'(IVP_SRC_TRAP);
                    next_kind = IVP_KIND_JUMP;
                    next_target = IVP_TRAP_TARGET;
                    next_state = IVP_DELIVER;
                end else if (grant[IVP_SRC_NMI]) begin
                    next_win = 4'(IVP_SRC_NMI);
                    next_pf_pend = pf_fall; // A new edge now stays pending
                    next_pf_act = 1'b1; // [RL6]
                    next_kind = IVP_KIND_JUMP; // [RL7]
                    next_target = POWER_FAIL_JUMP_SLOT; // [RL6]
                    next_state = IVP_DELIVER;
                end else if (grant[IVP_SRC_LVL0]) begin
                    next_win = 4'(IVP_SRC_LVL0);
                    next_kind = IVP_KIND_JUMP; // [RL7]
                    next_target = IVP_LVL0_TARGET;
                    next_state = IVP_DELIVER;
                end else if (|req) begin
                    for (int i = 3; i < 12; i++) begin
                        if (grant[i]) begin
                            next_win = 4'(i);
                        end
                    end
                    next_state = IVP_FETCH_LO;
                end
            end
            IVP_FETCH_LO: begin
                next_addr = {vector_page_base, offs}; // [RL1]
                next_rd = 1'b1; // [RL4]
                next_state = IVP_FETCH_HI;
            end
            IVP_FETCH_HI: begin
                next_lo = tbl_data; // Low byte first [RL10]
                next_addr = addr_q + 16'(1); // [RL10]
                next_rd = 1'b1;
                next_state = IVP_DELIVER;
            end
            IVP_DELIVER: begin
                if (!deliver) begin
                    next_deliver = 1'b1;
                    if (deliver_kind == IVP_KIND_NONE) begin
                        next_kind = IVP_KIND_TABLE;
                        next_target = {tbl_data, lo_q}; // Fetched handler [RL4]
                    end
                end else if (core_ack) begin
                    next_deliver = 1'b0;
                    next_kind = IVP_KIND_NONE;
                    next_state = IVP_IDLE;
                end
            end
            default: next_state = IVP_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer: registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IVP_IDLE;
            pf_pend <= 1'b0;
            pf_act <= 1'b0;
            win <= 4'h0;
            addr_q <= 16'h0000;
            lo_q <= 8'h00;
            tbl_rd <= 1'b0;
            deliver <= 1'b0;
            deliver_kind <= IVP_KIND_NONE;
            deliver_target <= 16'h0000;
        end else begin
            state <= next_state;
            pf_pend <= next_pf_pend;
            pf_act <= next_pf_act;
            win <= next_win;
            addr_q <= next_addr;
            lo_q <= next_lo;
            tbl_rd <= next_rd;
            deliver <= next_deliver;
            deliver_kind <= next_kind;
            deliver_target <= next_target;
        end
    end

    // Outputs taken from flops
    assign tbl_addr = addr_q;
    assign deliver_src = win;
    assign power_fail_active = pf_act;
endmodule : ivp_core
`default_nettype wire

// file: hw/ivp_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module ivp_edge_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin side
    input wire logic pin_n,
    // Clean side
    output logic fall
);
    logic s1, s2, s3, level, next_level, next_fall;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    always_comb begin
        next_level = level;
        next_fall = 1'b0;
        if (s2 == s3) begin
            next_level = s3;
            next_fall = level & ~s3; // Falling edge only, a held low gives one event
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            level <= 1'b1;
            fall <= 1'b0;
        end else begin
            s1 <= pin_n;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
            fall <= next_fall;
        end
    end
endmodule : ivp_edge_sync
`default_nettype wire

// file: hw/ivp_pkg.sv
package ivp_pkg;

    // ------------------------------------------------------------
    // Source indices, highest priority first
    // ------------------------------------------------------------
    localparam int IVP_NSRC = 11;
    localparam int IVP_SRC_TRAP = 0;
    localparam int IVP_SRC_NMI = 1;
    localparam int IVP_SRC_LVL0 = 2;
    localparam int IVP_SRC_LVL1 = 3;
    localparam int IVP_SRC_LVL2 = 4;
    localparam int IVP_SRC_TMR0 = 5;
    localparam int IVP_SRC_TMR1 = 6;
    localparam int IVP_SRC_XFR0 = 7;
    localparam int IVP_SRC_XFR1 = 8;
    localparam int IVP_SRC_SER0 = 9;
    localparam int IVP_SRC_SER1 = 10;
    localparam int IVP_NVEC = 9;

    // ------------------------------------------------------------
    // Vector offsets within the vector page
    // ------------------------------------------------------------
    localparam logic [7:0] EXPANSION_ATTENTION_VECTOR = 8'h00;
    localparam logic [7:0] LEVEL2_VECTOR = 8'h02;
    localparam logic [7:0] TIMER0_VECTOR = 8'h04;
    localparam logic [7:0] TIMER1_VECTOR = 8'h06;
    localparam logic [7:0] TRANSFER_CH0_VECTOR = 8'h08;
    localparam logic [7:0] TRANSFER_CH1_VECTOR = 8'h0A;
    localparam logic [7:0] CLOCKED_SERIAL_VECTOR = 8'h0C;
    localparam logic [7:0] ASYNC_SERIAL0_VECTOR = 8'h0E;
    localparam logic [7:0] ASYNC_SERIAL1_VECTOR = 8'h10;
    localparam logic [7:0] IVP_ENTRY_BYTES = 8'h02;

    // ------------------------------------------------------------
    // Fixed jump targets
    // ------------------------------------------------------------
    localparam logic [15:0] POWER_FAIL_JUMP_SLOT = 16'h0066;
    localparam logic [15:0] IVP_TRAP_TARGET = 16'h0000;
    localparam logic [15:0] IVP_LVL0_TARGET = 16'h0038;

    // ------------------------------------------------------------
    // Delivery kinds and sequencer states
    // ------------------------------------------------------------
    localparam logic [1:0] IVP_KIND_NONE = 2'h0;
    localparam logic [1:0] IVP_KIND_JUMP = 2'h1;
    localparam logic [1:0] IVP_KIND_TABLE = 2'h2;

    typedef enum logic [3:0] {
        IVP_IDLE = 4'h1,
        IVP_FETCH_LO = 4'h2,
        IVP_FETCH_HI = 4'h4,
        IVP_DELIVER = 4'h8
    } ivp_state_t;

endpackage : ivp_pkg

// file: tb/ivp_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// --------
// Port checks on the vectoring core
// --------
module ivp_core_asserts
    import ivp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Requests and control
    input wire logic illegal_opcode_trap,
    input wire logic power_fail_input_n,
    input wire logic [7:0] vector_page_base,
    input wire logic core_ack,
    // Table port
    input wire logic tbl_rd,
    input wire logic [15:0] tbl_addr,
    input wire logic [7:0] tbl_data,
    // Delivery
    input wire logic deliver,
    input wire logic [1:0] deliver_kind,
    input wire logic [15:0] deliver_target,
    input wire logic [3:0] deliver_src,
    input wire logic power_fail_active
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Entry reads start in the page, on an even offset no higher than the last slot
    a_entry_in_page: assert property ($rose(tbl_rd) |-> (tbl_addr[15:8] == vector_page_base
        && tbl_addr[7:0] <= 8'h10 && !tbl_addr[0])) else $error("entry read off the page");
    a_high_byte_next: assert property ($rose(tbl_rd) |=> (tbl_rd
        && tbl_addr == $past(tbl_addr) + 16'h0001) ##1 (deliver && deliver_kind == IVP_KIND_TABLE))
        else $error("entry fetch sequence broken");
    a_fetched_target: assert property ($rose(tbl_rd) ##2 1'b1 |->
        deliver_target == {$past(tbl_data), $past(tbl_data, 2)}) else $error("target not fetched");
    // Delivery stands until taken, then leaves at once
    a_deliver_stands: assert property (deliver && !core_ack |=> deliver
        && $stable(deliver_target) && $stable(deliver_src)) else $error("delivery changed early");
    a_ack_drops: assert property (deliver && core_ack |=> !deliver) else $error("delivery kept");
    a_power_fail_slot: assert property (deliver && deliver_src == IVP_SRC_NMI |->
        deliver_kind == IVP_KIND_JUMP && deliver_target == POWER_FAIL_JUMP_SLOT)
        else $error("power-fail target wrong");
    a_pf_blocks_others: assert property (power_fail_active && deliver |->
        deliver_src <= 4'h1) else $error("maskable source served in power fail");
    // Slack covers a standing delivery with a slow acknowledge before the take
    a_pf_edge_taken: assert property ($fell(power_fail_input_n) && !power_fail_active
        && !illegal_opcode_trap |-> ##[1:30] (deliver && deliver_src == IVP_SRC_NMI))
        else $error("power-fail edge not taken");
    c_table_fetch: cover property ($rose(tbl_rd));
    c_pf_taken: cover property (deliver && deliver_src == IVP_SRC_NMI);
    c_slow_ack: cover property (deliver [*5] ##1 core_ack);
endmodule : ivp_core_asserts
bind ivp_core ivp_core_asserts i_chk (.mclk, .rst_n, .illegal_opcode_trap, .power_fail_input_n,
    .vector_page_base, .core_ack, .tbl_rd, .tbl_addr, .tbl_data, .deliver, .deliver_kind,
    .deliver_target, .deliver_src, .power_fail_active);
`default_nettype wire

// file: tb/ivp_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// --------
// Core side: table memory and acknowledge
// --------
module ivp_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Table port
    input wire logic tbl_rd,
    input wire logic [15:0] tbl_addr,
    output logic [7:0] tbl_data,
    // Delivery handshake
    input wire logic deliver,
    input wire logic [3:0] ack_wait,
    output logic core_ack
);
    logic [3:0] wait_cnt;
    logic [7:0] junk;
    // Entries as software left them, a pattern of the address
    // Unread memory drifts so a stale byte is never taken for a good one
    assign tbl_data = tbl_rd ? (tbl_addr[7:0] ^ tbl_addr[15:8] ^ 8'hA5) : junk;
    // One-cycle acknowledge after ack_wait cycles of standing delivery
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            core_ack <= 1'b0;
            junk <= 8'h3C;
        end else begin
            junk <= junk + 8'h3B;
            core_ack <= deliver && !core_ack && wait_cnt == ack_wait;
            wait_cnt <= (deliver && !core_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : ivp_core_model
`default_nettype wire

// file: tb/tb_interrupt_vector_priority.sv
`timescale 1ns/1ns
`default_nettype none
// --------
// Bench for the vectoring core
// --------
module tb_interrupt_vector_priority
    import ivp_pkg::*;
;
    logic mclk, rst_n, power_fail_input_n, int_enable, power_fail_return;
    logic tbl_rd, core_ack, deliver, power_fail_active;
    logic [11:0] reqs;
    logic [10:0] src_enable;
    logic [7:0] vector_page_base, tbl_data;
    logic [3:0] ack_wait, deliver_src;
    logic [15:0] tbl_addr, deliver_target;
    logic [1:0] deliver_kind;
    int err_count, compares;

    // Request bit n is source index n, but bit 1 drives nothing (power fail comes from its pin); bit 11 is the clocked serial port
    ivp_core i_dut (
        .mclk, .rst_n, .power_fail_input_n, .vector_page_base, .int_enable, .src_enable,
        .illegal_opcode_trap(reqs[0]), .level0_req(reqs[2]), .level1_req(reqs[3]),
        .level2_req(reqs[4]), .timer0_req(reqs[5]), .timer1_req(reqs[6]),
        .transfer_ch0_req(reqs[7]), .transfer_ch1_req(reqs[8]), .async_serial0_req(reqs[9]),
        .async_serial1_req(reqs[10]), .clocked_serial_req(reqs[11]), .power_fail_return,
        .core_ack, .tbl_rd, .tbl_addr, .tbl_data, .deliver, .deliver_kind, .deliver_target,
        .deliver_src, .power_fail_active
    );
    ivp_core_model i_core (.mclk, .rst_n, .tbl_rd, .tbl_addr, .tbl_data, .deliver, .ack_wait,
        .core_ack);

    function automatic logic [7:0] ebyte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : ebyte
    // Expected handler address or jump slot for each source
    function automatic logic [15:0] expect_target(input int s);
        logic [7:0] offs [3:11];
        logic [15:0] a;
        offs = '{EXPANSION_ATTENTION_VECTOR, LEVEL2_VECTOR, TIMER0_VECTOR, TIMER1_VECTOR,
            TRANSFER_CH0_VECTOR, TRANSFER_CH1_VECTOR, ASYNC_SERIAL0_VECTOR,
            ASYNC_SERIAL1_VECTOR, CLOCKED_SERIAL_VECTOR};
        if (s == 0) return IVP_TRAP_TARGET;
        if (s == 1) return POWER_FAIL_JUMP_SLOT;
        if (s == 2) return IVP_LVL0_TARGET;
        a = {vector_page_base, offs[s]};
        return {ebyte(a + 16'h0001), ebyte(a)};
    endfunction : expect_target

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Raise a request, judge the delivery, then wait for it to leave
    task automatic serve(input int s);
        int n;
        logic [15:0] kind_exp;
        n = 0;
        kind_exp = (s < 3) ? 16'(IVP_KIND_JUMP) : 16'(IVP_KIND_TABLE);
        reqs[s] = 1'b1;
        while (deliver !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("kind", 16'(deliver_kind), kind_exp);
        check("target", deliver_target, expect_target(s));
        check("source", 16'(deliver_src), 16'(s));
        reqs[s] = 1'b0;
        while (deliver !== 1'b0 && n < 80) begin
            @(posedge mclk);
            #1;
            n++;
        end
        // A delivery that never leaves counts against the run
        check("released", 16'(deliver), 16'h0000);
    endtask : serve
    // Ten cycles in which nothing may be delivered
    task automatic quiet(input string name);
        logic seen;
        seen = 1'b0;
        repeat (10) begin
            @(posedge mclk);
            #1;
            seen = seen | deliver;
        end
        check(name, 16'(seen), 16'h0000);
    endtask : quiet

    task automatic t_each_source();
        vector_page_base = 8'h3C;
        for (int s = 0; s < 12; s++) if (s != 1) serve(s);
    endtask : t_each_source
    // Every source but power fail at once on another page, slow core: served strictly in rank
    task automatic t_priority();
        vector_page_base = 8'hC3;
        ack_wait = 4'h5;
        reqs = 12'hFFC;
        for (int s = 0; s < 12; s++) if (s != 1) serve(s);
    endtask : t_priority
    task automatic t_masks();
        int_enable = 1'b0;
        reqs[IVP_SRC_TMR0] = 1'b1;
        quiet("global_mask");
        int_enable = 1'b1;
        src_enable[IVP_SRC_TMR0] = 1'b0;
        quiet("source_mask");
        src_enable[IVP_SRC_TMR0] = 1'b1;
        serve(IVP_SRC_TMR0);
    endtask : t_masks
    // Power-fail edge with maskables off, then only the trap may pass
    task automatic t_power_fail();
        int_enable = 1'b0;
        power_fail_input_n = 1'b0;
        serve(IVP_SRC_NMI);
        check("pf_active", 16'(power_fail_active), 16'h0001);
        int_enable = 1'b1;
        reqs[IVP_SRC_TMR0] = 1'b1;
        quiet("pf_blocks");
        serve(IVP_SRC_TRAP);
        power_fail_return = 1'b1;
        @(posedge mclk);
        #1;
        power_fail_return = 1'b0;
        check("pf_cleared", 16'(power_fail_active), 16'h0000);
        serve(IVP_SRC_TMR0);
        power_fail_input_n = 1'b1;
    endtask : t_power_fail

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        {rst_n, power_fail_return, reqs, ack_wait} = '0;
        {power_fail_input_n, int_enable, src_enable} = {2'b11, 11'h7FF};
        {vector_page_base, err_count, compares} = '0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_each_source();
        t_priority();
        t_masks();
        t_power_fail();
        end_sim();
    end
    // A hang costs more than ten times the expected run
    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        end_sim();
    end
endmodule : tb_interrupt_vector_priority
`default_nettype wire
